// File: logic/uspc_ctrl.sv
// top: mode control, acknowledges, fault latching and fault pin of the port protection controller
// Functional notes
// - three modes selected by control writes
// - enable low holds reset, no i2c
// - off state: gate off, cc open, flag released
// - after enable, hibernate with everything off
// - low power: cc high impedance, i2c alive
// - low power: clamp only, power paths off
// - normal: fault pin on errors, bits steer outputs
// - fault pin is open drain
// - target address 0110 10x
// - address lsb from strap pin
// - control register field layout
// - supply routing decode, 11 opens both
// - acknowledge register mirrors control bits
// - flag register field layout
// - flags read one while active
// - overcurrent clears acks, sets flag, pin
// - recovery word re-enables operation
// - fault pin held until recovery word after overcurrent; voltage and heat errors release it when they clear
`timescale 1ns/1ns
module uspc_ctrl #(
  parameter logic VARIANT_ID = 1'b1  // arbitrary variant identifier value
) (
  input  wire logic                  i_clock,     // system clock, 20 MHz
  input  wire logic                  i_rst,       // async reset, high while enable pin low
  input  wire logic                  i_scl,       // i2c clock pin, link clock
  input  wire logic                  i_sda,       // i2c data pin level
  input  wire logic                  i_addr_strap,// address lsb strap pin
  input  wire uspc_pkg::uspc_fault_t i_fault,     // raw fault comparators
  output logic                       o_sda_oe_n,  // low pulls data pin low
  output logic                       o_fault_out_n_oe_n, // low pulls fault pin low
  output uspc_pkg::uspc_drive_t      o_drive,     // power stage controls
  output logic [7:0]                 o_port_control // current control register
);

  ////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] strap_sync;
  logic       addr_lsb;
  logic [1:0] strap_age;
  uspc_pkg::uspc_fault_t fault_s1;
  uspc_pkg::uspc_fault_t fault_s2;
  logic [2:0] tog_sync;
  logic [7:0] ack_reg;
  logic [7:0] flag_reg;
  logic [7:0] wr_data;
  logic       wr_toggle;
  logic [7:0] ctl;
  logic       oc_latched;
  logic [4:0] flags;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_sync <= 2'h0;
      fault_s1   <= '0;
      fault_s2   <= '0;
      tog_sync   <= 3'h0;
    end
    else
    begin
      strap_sync <= {strap_sync[0], i_addr_strap};
      fault_s1   <= i_fault;
      fault_s2   <= fault_s1;
      tog_sync   <= {tog_sync[1:0], wr_toggle};
    end
  end

  // strap frozen on the third edge after reset, once the synchroniser holds it
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      addr_lsb  <= 1'b0;
      strap_age <= 2'h0;
    end
    else if (strap_age != 2'h3)
    begin
      addr_lsb  <= strap_sync[1];
      strap_age <= strap_age + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // link side target (reset also keeps it silent while enable low)
  uspc_i2c_target u_target (
    .i_scl       (i_scl),
    .i_rst       (i_rst),
    .i_sda       (i_sda),
    .i_addr_lsb  (addr_lsb),
    .i_ack_reg   (ack_reg),
    .i_flag_reg  (flag_reg),
    .o_sda_oe_n  (o_sda_oe_n),
    .o_wr_data   (wr_data),
    .o_wr_toggle (wr_toggle)
  );

  ////////////////////////////////////////////////////////////////
  // control register and decode
  wire wr_event = tog_sync[2] ^ tog_sync[1];
  // data is stable across the toggle crossing, sampled when the event lands
  wire is_recovery = (wr_data & uspc_pkg::RECOVERY_MASK) == uspc_pkg::RECOVERY_WORD;

  uspc_pkg::uspc_mode_t mode;
  assign mode = uspc_pkg::uspc_mode_t'(ctl[uspc_pkg::CTL_SEL_HI_BIT -: 2] == 2'h2 ? 2'h2 :
                                       ctl[uspc_pkg::CTL_SEL_HI_BIT -: 2] == 2'h1 ? 2'h1 :
                                       ctl[uspc_pkg::CTL_SEL_HI_BIT -: 2] == 2'h0 ? 2'h0 : 2'h3);

  wire normal  = mode == uspc_pkg::USPC_NORMAL;
  wire lowpwr  = mode == uspc_pkg::USPC_LOW_POWER;
  wire [1:0] route = ctl[uspc_pkg::CTL_ROUTE_B_BIT -: 2];
  wire run     = normal && !oc_latched;
  wire oc_now  = normal && (fault_s2.bus_overcurrent || fault_s2.cable_overcurrent);

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctl        <= uspc_pkg::CTL_RESET;
      oc_latched <= 1'b0;
    end
    else
    begin
      if (wr_event)
        ctl <= wr_data;
      if (oc_now)
        oc_latched <= 1'b1;
      else if (wr_event && is_recovery)
        oc_latched <= 1'b0;
    end
  end

  // error flags, only the overcurrent bits sticky; a set wins over the recovery clear
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      flags <= 5'h00;
    else if (normal)
      flags <= {fault_s2.bus_overvolt, fault_s2.cc_overvolt, fault_s2.overtemp,
                fault_s2.bus_overcurrent | (flags[1] & ~(wr_event & is_recovery)),
                fault_s2.cable_overcurrent | (flags[0] & ~(wr_event & is_recovery))};
    else
      flags <= 5'h00;
  end

  ////////////////////////////////////////////////////////////////
  // readable registers and outputs
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_reg  <= 8'h00;
      flag_reg <= 8'h00;
    end
    else
    begin
      ack_reg  <= oc_latched ? {ctl[7:4], 4'h0} : ctl;
      flag_reg <= {VARIANT_ID, 1'b0, flags[4:2], 1'b0, flags[1:0]};
    end
  end

  // fault pin and power stage
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_fault_out_n_oe_n <= 1'b1;
      o_drive            <= '0;
      o_port_control     <= uspc_pkg::CTL_RESET;
    end
    else
    begin
      o_fault_out_n_oe_n <= !(normal && (|flags || oc_now || oc_latched));
      o_port_control <= ctl;
      o_drive.provider_gate_ctl         <= run && ctl[uspc_pkg::CTL_GATE_BIT];
      o_drive.bus_power_discharge_en    <= normal && (oc_latched || ctl[uspc_pkg::CTL_BUS_DIS_BIT]);
      o_drive.cable_supply_discharge_en <= normal && (oc_latched || ctl[uspc_pkg::CTL_CABLE_DIS_BIT]);
      o_drive.supply_switch_side_two    <= run && route == 2'h2;
      o_drive.supply_switch_side_one    <= run && route == 2'h1;
      o_drive.cc_switch_full            <= normal;
      o_drive.cc_switch_clamp           <= lowpwr;
      o_drive.current_sense_en          <= normal;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  property p_gate_mode;
    @(posedge i_clock) disable iff (i_rst)
    o_drive.provider_gate_ctl |-> $past(normal) && $past(ctl[2]);
  endproperty
  a_gate_mode: assert property (p_gate_mode) else $error("gate on outside normal");

  property p_lp_off;
    @(posedge i_clock) disable iff (i_rst)
    $past(lowpwr) |-> !o_drive.provider_gate_ctl && !o_drive.bus_power_discharge_en && o_drive.cc_switch_clamp;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("low power paths not off");

  property p_oc_flag;
    @(posedge i_clock) disable iff (i_rst)
    oc_now ##1 normal |=> !o_fault_out_n_oe_n && ack_reg[3:0] == 4'h0;
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent not signalled");

  property p_hold;
    @(posedge i_clock) disable iff (i_rst)
    oc_latched && !wr_event && normal |=> oc_latched;
  endproperty
  a_hold: assert property (p_hold) else $error("overcurrent released early");

  property p_route11;
    @(posedge i_clock) disable iff (i_rst)
    route == 2'h3 |=> !o_drive.supply_switch_side_one && !o_drive.supply_switch_side_two;
  endproperty
  a_route11: assert property (p_route11) else $error("route 11 closed a switch");

  property p_flag_quiet;
    @(posedge i_clock) disable iff (i_rst)
    !normal |=> o_fault_out_n_oe_n;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("fault pin outside normal");

  property p_bit6;
    @(posedge i_clock) disable iff (i_rst)
    flag_reg[6] == 1'b0 && flag_reg[2] == 1'b0;
  endproperty
  a_bit6: assert property (p_bit6) else $error("reserved flag bit set");

  property p_ack;
    @(posedge i_clock) disable iff (i_rst)
    !oc_latched ##1 !oc_latched |-> ack_reg == $past(ctl);
  endproperty
  a_ack: assert property (p_ack) else $error("ack mismatch");

  property p_idle_off;
    @(posedge i_clock) disable iff (i_rst)
    !normal && !lowpwr |=> o_drive == '0 && o_fault_out_n_oe_n;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("power stage on in hibernate");

  property p_unused;
    @(posedge i_clock) disable iff (i_rst)
    ctl[uspc_pkg::CTL_SEL_HI_BIT -: 2] == 2'h3 |=> o_drive == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused mode drives the power stage");

  property p_lp_sense;
    @(posedge i_clock) disable iff (i_rst)
    lowpwr |=> !o_drive.current_sense_en && !o_drive.cc_switch_full && !o_drive.cable_supply_discharge_en;
  endproperty
  a_lp_sense: assert property (p_lp_sense) else $error("sense or full cc path on in low power");

  property p_follow;
    @(posedge i_clock) disable iff (i_rst)
    run |=> o_drive.provider_gate_ctl == $past(ctl[uspc_pkg::CTL_GATE_BIT]) &&
            o_drive.bus_power_discharge_en == $past(ctl[uspc_pkg::CTL_BUS_DIS_BIT]) &&
            o_drive.cable_supply_discharge_en == $past(ctl[uspc_pkg::CTL_CABLE_DIS_BIT]);
  endproperty
  a_follow: assert property (p_follow) else $error("normal outputs do not follow control bits");

  property p_ov_pin;
    @(posedge i_clock) disable iff (i_rst)
    normal && (fault_s2.bus_overvolt || fault_s2.cc_overvolt || fault_s2.overtemp) ##1 normal
      |=> !o_fault_out_n_oe_n;
  endproperty
  a_ov_pin: assert property (p_ov_pin) else $error("fault pin idle on voltage or heat error");

  property p_oc_off;
    @(posedge i_clock) disable iff (i_rst)
    oc_latched |=> !o_drive.provider_gate_ctl && !o_drive.supply_switch_side_one &&
                   !o_drive.supply_switch_side_two;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("switch on during overcurrent latch");

  property p_oc_dis;
    @(posedge i_clock) disable iff (i_rst)
    normal && oc_latched |=> o_drive.bus_power_discharge_en && o_drive.cable_supply_discharge_en;
  endproperty
  a_oc_dis: assert property (p_oc_dis) else $error("discharge off during overcurrent latch");

  property p_recover;
    @(posedge i_clock) disable iff (i_rst)
    normal && oc_latched && wr_event && is_recovery && !oc_now |=> !oc_latched;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery word did not release latch");

  property p_flags_idle;
    @(posedge i_clock) disable iff (i_rst)
    !normal |=> flags == 5'h00;
  endproperty
  a_flags_idle: assert property (p_flags_idle) else $error("error flag set outside normal");

  property p_write;
    @(posedge i_clock) disable iff (i_rst)
    wr_event |=> ctl == $past(wr_data);
  endproperty
  a_write: assert property (p_write) else $error("control write lost");

  property p_strap;
    @(posedge i_clock) disable iff (i_rst)
    strap_age == 2'h3 |=> $stable(addr_lsb);
  endproperty
  a_strap: assert property (p_strap) else $error("address bit moved after capture");

  c_write:    cover property (@(posedge i_clock) disable iff (i_rst) wr_event);
  c_lowpower: cover property (@(posedge i_clock) disable iff (i_rst) lowpwr);
  c_pin_low:  cover property (@(posedge i_clock) disable iff (i_rst) !o_fault_out_n_oe_n);
  c_trip:     cover property (@(posedge i_clock) disable iff (i_rst) $rose(oc_latched));
  c_recover:  cover property (@(posedge i_clock) disable iff (i_rst) $fell(oc_latched));

endmodule : uspc_ctrl

// File: logic/uspc_pkg.sv
// package: register map, field layout and constants of the port protection controller
package uspc_pkg;

  localparam logic [7:0] REG_PORT_CONTROL = 8'h00;
  localparam logic [7:0] REG_CONTROL_ACK  = 8'h01;
  localparam logic [7:0] REG_FAULT_FLAGS  = 8'h02;

  // port_control fields
  localparam int CTL_CABLE_DIS_BIT = 7;
  localparam int CTL_BUS_DIS_BIT   = 6;
  localparam int CTL_SEL_HI_BIT    = 5;
  localparam int CTL_SEL_LO_BIT    = 4;
  localparam int CTL_ONE_BIT       = 3;
  localparam int CTL_GATE_BIT      = 2;
  localparam int CTL_ROUTE_B_BIT   = 1;
  localparam int CTL_ROUTE_A_BIT   = 0;

  // fault_flags fields
  localparam int FLG_VARIANT_BIT  = 7;
  localparam int FLG_BUS_OV_BIT   = 5;
  localparam int FLG_CC_OV_BIT    = 4;
  localparam int FLG_OT_BIT       = 3;
  localparam int FLG_BUS_OC_BIT   = 1;
  localparam int FLG_CABLE_OC_BIT = 0;

  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [7:0] RECOVERY_MASK = 8'hcf;
  localparam logic [7:0] RECOVERY_WORD = 8'h08;

  localparam logic [5:0] ADDR_UPPER = 6'h1a;

  localparam int FILT_STAGES = 2;

  typedef enum logic [1:0] {
    USPC_HIBERNATE = 2'h0,
    USPC_NORMAL    = 2'h1,
    USPC_LOW_POWER = 2'h2,
    USPC_UNUSED    = 2'h3
  } uspc_mode_t;

  // fault inputs from the analog side
  typedef struct packed {
    logic bus_overvolt;
    logic cc_overvolt;
    logic overtemp;
    logic bus_overcurrent;
    logic cable_overcurrent;
  } uspc_fault_t;

  // outputs to the power stage
  typedef struct packed {
    logic cable_supply_discharge_en;
    logic bus_power_discharge_en;
    logic provider_gate_ctl;
    logic supply_switch_side_two;
    logic supply_switch_side_one;
    logic cc_switch_full;
    logic cc_switch_clamp;
    logic current_sense_en;
  } uspc_drive_t;

endpackage : uspc_pkg

// File: logic/uspc_i2c_target.sv
// i2c target on the link clock: addressing, index byte, register reads and writes
`timescale 1ns/1ns
module uspc_i2c_target (
  input  wire logic       i_scl,        // link clock (i2c clock pin)
  input  wire logic       i_rst,        // async reset, enable low
  input  wire logic       i_sda,        // data pin level
  input  wire logic       i_addr_lsb,   // strapped address bit
  input  wire logic [7:0] i_ack_reg,    // acknowledge register, system domain
  input  wire logic [7:0] i_flag_reg,   // flag register, system domain
  output logic            o_sda_oe_n,   // low pulls data pin low
  output logic [7:0]      o_wr_data,    // last written control byte
  output logic            o_wr_toggle   // flips on each control write
);

  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] index;
  logic       selected;
  logic       is_read;
  logic       phase_addr;
  logic       got_index;
  logic       start_seen;
  logic [7:0] tx;
  logic       start_taken;

  wire        addr_hit   = shift[7:1] == {uspc_pkg::ADDR_UPPER, i_addr_lsb};
  wire  [7:0] next_shift = {shift[6:0], i_sda};
  wire        start_now  = start_seen != start_taken;
  wire  [7:0] rd_sel     = index == uspc_pkg::REG_CONTROL_ACK ? i_ack_reg :
                           index == uspc_pkg::REG_FAULT_FLAGS ? i_flag_reg : 8'h00;

  // start detect: data falling while clock high flips a toggle, taken at the next rising clock
  always_ff @(negedge i_sda or posedge i_rst)
    if (i_rst)
      start_seen <= 1'b0;
    else if (i_scl)
      start_seen <= ~start_seen;

  // receive on rising edge
  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      shift       <= 8'h00;
      bit_cnt     <= 4'h0;
      phase_addr  <= 1'b1;
      selected    <= 1'b0;
      is_read     <= 1'b0;
      got_index   <= 1'b0;
      index       <= 8'h00;
      o_wr_data   <= 8'h00;
      o_wr_toggle <= 1'b0;
      start_taken <= 1'b0;
    end
    else
    begin
      start_taken <= start_seen;
      if (start_now)
      begin
        bit_cnt    <= 4'h1;
        phase_addr <= 1'b1;
        shift      <= {7'h00, i_sda};
      end
      else if (bit_cnt == 4'h8)
      begin
        bit_cnt <= 4'h0;
        if (phase_addr)
        begin
          phase_addr <= 1'b0;
          selected   <= addr_hit;
          is_read    <= shift[0];
          got_index  <= 1'b0;
        end
        else if (selected && !is_read)
        begin
          if (!got_index)
          begin
            index     <= shift;
            got_index <= 1'b1;
          end
          else if (index == uspc_pkg::REG_PORT_CONTROL)
          begin
            o_wr_data   <= shift;
            o_wr_toggle <= ~o_wr_toggle;
          end
        end
      end
      else
      begin
        shift   <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // drive on falling edge: ack after address/writes, data bits on reads
  always_ff @(negedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sda_oe_n  <= 1'b1;
      tx          <= 8'hff;
    end
    else
    begin
      if (bit_cnt == 4'h8 && (phase_addr ? addr_hit : (selected && !is_read)))
      begin
        o_sda_oe_n <= 1'b0;
        tx         <= rd_sel;
      end
      else if (selected && is_read && !phase_addr && bit_cnt != 4'h8)
      begin
        o_sda_oe_n <= tx[7];
        tx         <= {tx[6:0], 1'b1};
      end
      else
        o_sda_oe_n <= 1'b1;
    end
  end

endmodule : uspc_i2c_target

// File: tb/uspc_pd_host.sv
// controller model: i2c master that makes the link clock and drives the data pin
`timescale 1ns/1ns
module uspc_pd_host #(
  parameter int QUARTER = 7  // link clock period is about four of these, 30 ns total
) (
  input  wire logic i_sda,      // resolved data pin
  output logic      o_scl,      // link clock, high between frames
  output logic      o_sda_oe_n  // low pulls data pin low
);
  initial
  begin
    o_scl      = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe_n = b;
    #QUARTER;
    o_scl = 1'b1;
    #QUARTER;
    s = i_sda;
    #(QUARTER + 1);
    o_scl = 1'b0;
    #(QUARTER + 1);
  endtask : bit_io

  task automatic start_cond;
    o_sda_oe_n = 1'b1;
    #QUARTER;
    o_scl = 1'b1;
    #(QUARTER + 1);
    o_sda_oe_n = 1'b0;
    #QUARTER;
    o_scl = 1'b0;
    #(QUARTER + 1);
  endtask : start_cond

  task automatic stop_cond;
    o_sda_oe_n = 1'b0;
    #QUARTER;
    o_scl = 1'b1;
    #(QUARTER + 1);
    o_sda_oe_n = 1'b1;
    #(2 * QUARTER);
  endtask : stop_cond

  // msb first, ninth bit released for the answer
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_io

  // index byte, then the data byte
  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0;
    logic       k1;
    logic       k2;
    start_cond();
    byte_io({a, 1'b0}, q, k0);
    byte_io(idx, q, k1);
    byte_io(d, q, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg

  // index byte, repeated start, one byte read with no acknowledge
  task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0;
    logic       k1;
    logic       k2;
    logic       k3;
    start_cond();
    byte_io({a, 1'b0}, q, k0);
    byte_io(idx, q, k1);
    start_cond();
    byte_io({a, 1'b1}, q, k2);
    byte_io(8'hff, d, k3);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : uspc_pd_host

// File: tb/uspc_ctrl_test.sv
// testbench of the port protection controller: control words, strap, faults and recovery
`timescale 1ns/1ns
module uspc_ctrl_test;
  localparam logic VAR_ID = 1'b1;  // arbitrary variant identifier value
  logic                  i_clock;
  logic                  i_rst;
  logic                  i_addr_strap;
  uspc_pkg::uspc_fault_t i_fault;
  uspc_pkg::uspc_drive_t o_drive;
  logic [7:0]            o_port_control;
  logic                  dut_sda_oe_n;
  logic                  host_sda_oe_n;
  logic                  scl;
  logic                  fault_oe_n;
  wire logic             sda = dut_sda_oe_n & host_sda_oe_n;  // pull-up on the wire
  wire logic             fault_out_n = fault_oe_n;  // pull-up, released reads high
  int                    failures;
  int                    comparisons;
  logic [7:0]            rnd;
  logic [6:0]            addr;

  uspc_ctrl #(.VARIANT_ID(VAR_ID)) dut_u (
    .i_clock            (i_clock),
    .i_rst              (i_rst),
    .i_scl              (scl),
    .i_sda              (sda),
    .i_addr_strap       (i_addr_strap),
    .i_fault            (i_fault),
    .o_sda_oe_n         (dut_sda_oe_n),
    .o_fault_out_n_oe_n (fault_oe_n),
    .o_drive            (o_drive),
    .o_port_control     (o_port_control)
  );

  uspc_pd_host host_u (.i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_sda_oe_n));

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  function automatic logic [7:0] next_rnd(input logic [7:0] v);
    next_rnd = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rnd

  // power stage expected from a control word
  function automatic logic [7:0] exp_drive(input logic [7:0] c);
    logic nm;
    nm = (c[5:4] == 2'b01);
    exp_drive = {c[7] & nm, c[6] & nm, c[2] & nm, c[1] & ~c[0] & nm, c[0] & ~c[1] & nm, nm, c[5:4] == 2'b10, nm};
  endfunction : exp_drive

  task automatic do_reset(input logic strap);
    @(negedge i_clock);
    i_rst        = 1'b1;
    i_addr_strap = strap;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clock);
    addr = {uspc_pkg::ADDR_UPPER, strap};
  endtask : do_reset

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    host_u.write_reg(addr, idx, d, ok);
    check("write ack", {7'h0, ok}, 8'h01);
    repeat (6) @(negedge i_clock);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic       ok;
    logic [7:0] q;
    host_u.read_reg(addr, idx, q, ok);
    check("read ack", {7'h0, ok}, 8'h01);
    check("read data", q, exp);
  endtask : rd

  initial
  begin
    repeat (100000) @(posedge i_clock);
    failures++;
    give_verdict();
  end

  initial
  begin
    logic       ok;
    logic [7:0] c;
    logic [7:0] q;
    int         pos;
    logic [7:0] corner [4];
    corner       = '{8'hdf, 8'h2b, 8'h3f, 8'h1f};
    i_rst        = 1'b1;
    i_fault      = '0;
    i_addr_strap = 1'b0;
    failures     = 0;
    comparisons  = 0;
    rnd          = 8'h3a;
    c            = 8'h00;
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      check("drive", o_drive, 8'h00);
      check("fault pin", {7'h0, fault_out_n}, 8'h01);
      check("control", o_port_control, uspc_pkg::CTL_RESET);
      host_u.write_reg({uspc_pkg::ADDR_UPPER, ~s[0]}, 8'h00, 8'h18, ok);
      check("foreign ack", {7'h0, ok}, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h02, {VAR_ID, 7'h0});
    end
    for (int i = 0; i < 16; i++)
    begin
      c   = (i < 4) ? corner[i] : rnd;
      rnd = next_rnd(rnd);
      wr(8'h00, c);
      check("control", o_port_control, c);
      check("drive", o_drive, exp_drive(c));
      rd(8'h01, c);
    end
    wr(8'h01, 8'hff);
    check("control", o_port_control, c);
    rd(8'h03, 8'h00);
    wr(8'h00, 8'h00);
    i_fault = uspc_pkg::uspc_fault_t'(5'h10);
    repeat (8) @(negedge i_clock);
    check("fault pin", {7'h0, fault_out_n}, 8'h01);
    i_fault = '0;
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h00, (k < 2) ? 8'hdf : 8'h18);
      i_fault = uspc_pkg::uspc_fault_t'(5'(1 << k));
      repeat (8) @(negedge i_clock);
      check("fault pin", {7'h0, fault_out_n}, 8'h00);
      pos = (k < 2) ? k : k + 1;
      rd(8'h02, {VAR_ID, 7'h0} | 8'(1 << pos));
      @(negedge i_clock);
      i_fault = '0;
      repeat (8) @(negedge i_clock);
      if (k < 2)
      begin
        check("fault pin", {7'h0, fault_out_n}, 8'h00);
        check("drive", o_drive & 8'hf8, 8'hc0);
        host_u.read_reg(addr, 8'h01, q, ok);
        check("acks", q & 8'h07, 8'h00);
        wr(8'h00, 8'h1c);
        check("fault pin", {7'h0, fault_out_n}, 8'h00);
        wr(8'h00, uspc_pkg::RECOVERY_WORD | 8'h10);
      end
      check("fault pin", {7'h0, fault_out_n}, 8'h01);
      rd(8'h02, {VAR_ID, 7'h0});
    end
    give_verdict();
  end
endmodule : uspc_ctrl_test
